// *** src/smr_cfg.svh ***
// Constants of the serial mode and status register block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from files under src/ and tb/.
`ifndef SMR_CFG_SVH
`define SMR_CFG_SVH

// Register byte offsets on the bus.
`define SMR_OFF_MODE 5'h00
`define SMR_OFF_STAT 5'h04
`define SMR_OFF_IRQ_STATUS 5'h08
`define SMR_OFF_IRQ_MASK 5'h0c
`define SMR_OFF_SLAVE_ADDR 5'h10

// Reset values.
`define SMR_RST_MODE 8'he0
`define SMR_RST_STAT 8'h81
`define SMR_RST_SLAVE_ADDR 8'h00

// Mode control fields.
`define SMR_MODE_MSB 7
`define SMR_MODE_LSB 5
`define SMR_DEB_MSB 3
`define SMR_DEB_LSB 2
`define SMR_EN_BIT 1
`define SMR_INC_BIT 0

// Two-wire status control fields.
`define SMR_HCF_BIT 7
`define SMR_MATCH_BIT 6
`define SMR_BUSY_BIT 5
`define SMR_TXSEL_BIT 4
`define SMR_ACKSEND_BIT 3
`define SMR_RW_BIT 2
`define SMR_WAKE_BIT 1
`define SMR_ACKRX_BIT 0

// Operating mode codes.
`define SMR_MODE_DIV4 3'h0
`define SMR_MODE_DIV16 3'h1
`define SMR_MODE_DIV64 3'h2
`define SMR_MODE_SUB 3'h3
`define SMR_MODE_TIMER 3'h4
`define SMR_MODE_SPI_SLAVE 3'h5
`define SMR_MODE_TWO_WIRE 3'h6

// Half-period masks of the free divider: a toggle every 2, 8 or 32 clocks.
`define SMR_HALF_DIV4 5'h01
`define SMR_HALF_DIV16 5'h07
`define SMR_HALF_DIV64 5'h1f

// Debounce counter limits; a change passes one clock later, after two or four system clocks.
`define SMR_DEB_SHORT 2'h1
`define SMR_DEB_LONG 2'h3

// Interrupt status bits.
`define SMR_IRQ_MATCH 0
`define SMR_IRQ_DONE 1
`define SMR_IRQ_INC 2

`endif

// *** src/smr_pkg.sv ***
// Types shared by the serial mode and status register block.
// Assumes nothing beyond a SystemVerilog compiler.
package smr_pkg;
   typedef logic [2:0] smr_mode_t;
   typedef logic [1:0] smr_deb_t;
   typedef logic [7:0] smr_byte_t;
   typedef enum {SMR_BUS_IDLE, SMR_BUS_ANSWER} smr_bus_state_t;
endpackage

// *** src/smr_debounce.sv ***
// Glitch filter for the two-wire clock input.
// Assumes the input is already synchronous to clk.
`timescale 1ns/1ps
`include "smr_cfg.svh"
module smr_debounce (
   input wire logic clk,
   input wire logic reset_n,
   input wire smr_pkg::smr_deb_t debSel,
   input wire logic sclIn,
   output logic sclOut
);
   import smr_pkg::*;

   logic filt;
   logic [1:0] stableCnt;
   logic [1:0] needCnt;

   // Zero selects a straight path; one needs two equal clocks, two or three need four.
   assign needCnt = (debSel == 2'h1) ? `SMR_DEB_SHORT : `SMR_DEB_LONG;
   assign sclOut = (debSel == 2'h0) ? sclIn : filt;

   // A change is passed only after it has held for the whole debounce span.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         filt <= 1'b1;
         stableCnt <= 2'h0;
      end else if (debSel == 2'h0 || sclIn == filt) begin
         filt <= (debSel == 2'h0) ? sclIn : filt;
         stableCnt <= 2'h0;
      end else if (stableCnt == needCnt) begin
         filt <= sclIn;
         stableCnt <= 2'h0;
      end else begin
         stableCnt <= stableCnt + 2'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_deb_pass: assert property (debSel == 2'h0 |-> sclOut == sclIn)
      else $error("Debounce off but clock input not passed straight.");
   a_deb_long_hold: assert property (debSel[1] && $stable(debSel) && $changed(filt)
      |-> $past(sclIn, 4) == filt)
      else $error("Long debounce passed a change held under four clocks.");
endmodule

// *** src/smr_top.sv ***
// Mode control and two-wire status registers of the shared serial module, with the
// master shift-clock source, input debounce, pin release and module interrupt.
// Assumes a serial engine outside that reports bus events as one-cycle pulses on clk.
//
// Implementation choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "smr_cfg.svh"

module smr_top (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic irq,
   input wire logic cfgOptionEn,
   input wire logic subClkIn,
   input wire logic periodMatch,
   input wire logic sclIn,
   output logic sclFiltered,
   input wire logic rxAddrValid,
   input wire logic [6:0] rxAddr,
   input wire logic rxReadReq,
   input wire logic byteStart,
   input wire logic byteDone,
   input wire logic ackIn,
   input wire logic busStart,
   input wire logic busStop,
   input wire logic spiIncompleteEvt,
   output logic spiClkOut,
   output logic spiClkOe,
   output logic twoWireFuncEn,
   output logic spiFuncEn,
   output logic moduleClkEn,
   output logic slaveTransmitSel,
   output logic ackSendSel,
   output logic addressWakeEn
);
   import smr_pkg::*;

   smr_bus_state_t busState;
   smr_mode_t operatingMode;
   smr_deb_t debounceSelect;
   smr_deb_t debEffective;
   smr_byte_t slaveAddr;
   logic interfaceEnable;
   logic spiIncomplete;
   logic transferComplete;
   logic addressMatch;
   logic busBusy;
   logic masterReadReq;
   logic ackReceived;
   logic [2:0] irqStatus;
   logic [2:0] irqMask;
   logic [4:0] divCnt;
   logic [4:0] halfMask;
   logic effEnable;
   logic prevEnable;
   logic enableRise;
   logic twoWireActive;
   logic masterMode;
   logic matchHit;
   logic doneHit;
   logic incHit;
   logic [2:0] evtHits;
   logic accept;
   logic wrMode;
   logic wrStat;
   logic [31:0] next_readdata;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus slave: one wait state, so read data can come from a flip-flop.

   assign waitrequest = (read || write) && (busState == SMR_BUS_IDLE);
   assign accept = (read || write) && (busState == SMR_BUS_ANSWER);
   assign wrMode = accept && write && byteenable[0] && (address == `SMR_OFF_MODE);
   assign wrStat = accept && write && byteenable[0] && (address == `SMR_OFF_STAT);

   // The answer phase lasts exactly one cycle, then the bus returns to idle.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         busState <= SMR_BUS_IDLE;
      end else begin
         case (busState)
            SMR_BUS_IDLE: busState <= (read || write) ? SMR_BUS_ANSWER : SMR_BUS_IDLE;
            SMR_BUS_ANSWER: busState <= SMR_BUS_IDLE;
            default: busState <= SMR_BUS_IDLE;
         endcase
      end
   end

   // Read mux; unmapped offsets read as zero.
   always_comb begin
      next_readdata = 32'h0000_0000;
      case (address)
         `SMR_OFF_MODE: next_readdata[7:0] = {operatingMode, 1'b0, debounceSelect,
            interfaceEnable, spiIncomplete};
         `SMR_OFF_STAT: next_readdata[7:0] = {transferComplete, addressMatch, busBusy,
            slaveTransmitSel, ackSendSel, masterReadReq, addressWakeEn, ackReceived};
         `SMR_OFF_IRQ_STATUS: next_readdata[2:0] = irqStatus;
         `SMR_OFF_IRQ_MASK: next_readdata[2:0] = irqMask;
         `SMR_OFF_SLAVE_ADDR: next_readdata[7:0] = slaveAddr;
         default: next_readdata = 32'h0000_0000;
      endcase
   end

   // Data are captured while waitrequest is high and stand through the answer cycle.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         readdata <= 32'h0000_0000;
      end else if (read && busState == SMR_BUS_IDLE) begin
         readdata <= next_readdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Enable gating and mode decode.

   assign effEnable = interfaceEnable && cfgOptionEn;
   assign enableRise = effEnable && !prevEnable;
   assign twoWireActive = effEnable && (operatingMode == `SMR_MODE_TWO_WIRE);
   assign masterMode = (operatingMode <= `SMR_MODE_TIMER);
   assign debEffective = (operatingMode == `SMR_MODE_TWO_WIRE) ? debounceSelect : 2'h0;
   assign matchHit = twoWireActive && rxAddrValid && (rxAddr == slaveAddr[7:1]);
   assign doneHit = twoWireActive && byteDone;
   assign incHit = effEnable && (operatingMode == `SMR_MODE_SPI_SLAVE) && spiIncompleteEvt;
   assign evtHits = {incHit, doneHit, matchHit};

   // Disabled: pins lose their serial use and the module clock gate closes.
   assign twoWireFuncEn = twoWireActive;
   assign spiFuncEn = effEnable && (masterMode || operatingMode == `SMR_MODE_SPI_SLAVE);
   assign moduleClkEn = effEnable;
   assign spiClkOe = effEnable && masterMode;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         prevEnable <= 1'b0;
      end else begin
         prevEnable <= effEnable;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Mode control register. SPI settings live elsewhere and are not touched by enabling.

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         operatingMode <= smr_mode_t'(`SMR_RST_MODE >> `SMR_MODE_LSB);
         debounceSelect <= 2'h0;
         interfaceEnable <= 1'b0;
      end else if (wrMode) begin
         operatingMode <= writedata[`SMR_MODE_MSB:`SMR_MODE_LSB];
         debounceSelect <= writedata[`SMR_DEB_MSB:`SMR_DEB_LSB];
         interfaceEnable <= writedata[`SMR_EN_BIT];
      end
   end

   // A slave-mode incomplete event beats a software clear in the same cycle.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         spiIncomplete <= 1'b0;
      end else if (incHit) begin
         spiIncomplete <= 1'b1;
      end else if (wrMode) begin
         spiIncomplete <= writedata[`SMR_INC_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Two-wire status: software owns only the select bits and the read/write copy.

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         slaveTransmitSel <= 1'((`SMR_RST_STAT >> `SMR_TXSEL_BIT) & 8'h01);
         ackSendSel <= 1'b0;
         addressWakeEn <= 1'b0;
      end else if (wrStat) begin
         slaveTransmitSel <= writedata[`SMR_TXSEL_BIT];
         ackSendSel <= writedata[`SMR_ACKSEND_BIT];
         addressWakeEn <= writedata[`SMR_WAKE_BIT];
      end
   end

   // Enabling the two-wire mode restores the flags; SPI enabling changes nothing.
   always_ff @(posedge clk) begin
      if (!reset_n || (enableRise && twoWireActive)) begin
         transferComplete <= 1'b1;
         addressMatch <= 1'b0;
         busBusy <= 1'b0;
         ackReceived <= 1'b1;
      end else begin
         if (doneHit) begin
            transferComplete <= 1'b1;
         end else if (twoWireActive && byteStart) begin
            transferComplete <= 1'b0;
         end
         if (matchHit) begin
            addressMatch <= 1'b1;
         end else if (twoWireActive && (busStart || busStop)) begin
            addressMatch <= 1'b0;
         end
         if (twoWireActive && busStart) begin
            busBusy <= 1'b1;
         end else if (twoWireActive && busStop) begin
            busBusy <= 1'b0;
         end
         if (doneHit) begin
            ackReceived <= ackIn;
         end
      end
   end

   // The read/write copy follows the bus on a match and software otherwise.
   always_ff @(posedge clk) begin
      if (!reset_n || (enableRise && twoWireActive)) begin
         masterReadReq <= 1'b0;
      end else if (matchHit) begin
         masterReadReq <= rxReadReq;
      end else if (wrStat) begin
         masterReadReq <= writedata[`SMR_RW_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt: sticky events, write one to clear, the set wins over the clear.

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irqStatus <= 3'h0;
         irqMask <= 3'h0;
         slaveAddr <= `SMR_RST_SLAVE_ADDR;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (evtHits[i]) begin
               irqStatus[i] <= 1'b1;
            end else if (accept && write && byteenable[0] && address == `SMR_OFF_IRQ_STATUS
               && writedata[i]) begin
               irqStatus[i] <= 1'b0;
            end
         end
         if (accept && write && byteenable[0] && address == `SMR_OFF_IRQ_MASK) begin
            irqMask <= writedata[2:0];
         end
         if (accept && write && byteenable[0] && address == `SMR_OFF_SLAVE_ADDR) begin
            slaveAddr <= writedata[7:0];
         end
      end
   end

   assign irq = |(irqStatus & irqMask);

   ////////////////////////////////////////////////////////////////////////////////
   // Master shift clock. The divider runs freely, so a new ratio lands on the next wrap.

   always_comb begin
      case (operatingMode)
         `SMR_MODE_DIV4: halfMask = `SMR_HALF_DIV4;
         `SMR_MODE_DIV16: halfMask = `SMR_HALF_DIV16;
         default: halfMask = `SMR_HALF_DIV64;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         divCnt <= 5'h00;
      end else begin
         divCnt <= divCnt + 5'h01;
      end
   end

   // Slave and two-wire modes leave the clock idle; the far master drives it then.
   always_ff @(posedge clk) begin
      if (!reset_n || !effEnable) begin
         spiClkOut <= 1'b0;
      end else begin
         case (operatingMode)
            `SMR_MODE_DIV4, `SMR_MODE_DIV16, `SMR_MODE_DIV64: begin
               if ((divCnt & halfMask) == halfMask) begin
                  spiClkOut <= !spiClkOut;
               end
            end
            `SMR_MODE_SUB: spiClkOut <= subClkIn;
            `SMR_MODE_TIMER: begin
               if (periodMatch) begin
                  spiClkOut <= !spiClkOut;
               end
            end
            default: spiClkOut <= 1'b0;
         endcase
      end
   end

   smr_debounce u_debounce (
      .clk(clk),
      .reset_n(reset_n),
      .debSel(debEffective),
      .sclIn(sclIn),
      .sclOut(sclFiltered)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_two_wire_enable;
      !effEnable ##1 (effEnable && operatingMode == `SMR_MODE_TWO_WIRE);
   endsequence

   a_div4_period: assert property ((effEnable && operatingMode == `SMR_MODE_DIV4)[*4]
      |-> spiClkOut != $past(spiClkOut, 2))
      else $error("Divide-by-four clock does not toggle every two cycles.");
   a_timer_half: assert property (effEnable && operatingMode == `SMR_MODE_TIMER
      && $stable(operatingMode) && periodMatch |=> $changed(spiClkOut))
      else $error("Timer match did not toggle the shift clock.");
   a_slave_noclk: assert property (operatingMode == `SMR_MODE_SPI_SLAVE
      |-> !spiClkOe ##1 (!spiClkOut || operatingMode != `SMR_MODE_SPI_SLAVE))
      else $error("Clock driven in slave mode.");
   // Watched at the filter's output, so a wrong select inside the filter shows too.
   a_deb_gate: assert property (operatingMode != `SMR_MODE_TWO_WIRE
      |-> sclFiltered == sclIn)
      else $error("Debounce active outside two-wire mode.");
   a_disable_pins: assert property (!effEnable |-> !twoWireFuncEn && !spiFuncEn
      && !moduleClkEn && !spiClkOe)
      else $error("Pins kept while disabled.");
   a_option_gate: assert property (!cfgOptionEn |-> !moduleClkEn ##1 !spiClkOut)
      else $error("Enable acted without the option.");
   a_enable_flags: assert property (s_two_wire_enable |=> transferComplete && !addressMatch
      && !busBusy && ackReceived && !masterReadReq && $stable(slaveTransmitSel))
      else $error("Two-wire enable did not restore the flags.");
   a_bit4_zero: assert property (read && busState == SMR_BUS_IDLE
      && address == `SMR_OFF_MODE |=> !readdata[4])
      else $error("Unimplemented mode bit read as one.");
   a_inc_gated: assert property (operatingMode != `SMR_MODE_SPI_SLAVE && !wrMode
      |=> $stable(spiIncomplete))
      else $error("Incomplete flag moved outside slave mode.");
   a_match_irq: assert property (matchHit && irqMask[`SMR_IRQ_MATCH]
      |=> addressMatch && irq)
      else $error("Address match missed flag or interrupt.");
   a_byte_flow: assert property (twoWireActive && byteStart && !byteDone
      |=> !transferComplete)
      else $error("Completion flag high during a byte.");
   a_ro_flags: assert property (wrStat && !enableRise && !busStart && !busStop && !matchHit
      && !byteDone |=> $stable(busBusy) && $stable(addressMatch))
      else $error("Software write changed a read-only flag.");
endmodule

// *** tb/smr_far_master.sv ***
// Far-side model of the external two-wire or SPI master that feeds the block's event inputs.
// Assumes the bench starts each event with a one-cycle go pulse taken on the rising clock edge.
`timescale 1ns/1ps
module smr_far_master (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic go,
   input wire logic [2:0] kind,
   input wire logic [6:0] addrIn,
   input wire logic bitIn,
   input wire logic [3:0] lowLen,
   output logic sclIn,
   output logic rxAddrValid,
   output logic [6:0] rxAddr,
   output logic rxReadReq,
   output logic byteStart,
   output logic byteDone,
   output logic ackIn,
   output logic busStart,
   output logic busStop,
   output logic spiIncompleteEvt
);
   logic [3:0] lowCnt;

   ////////////////////////////////////////////////////////////////////////////////
   // Each event is one pulse; outside a pulse the address and bit lines wander every
   // cycle, so a design that samples them at the wrong moment shows it.
   always_ff @(posedge clk) begin
      rxAddrValid <= reset_n && go && kind == 3'h0;
      byteStart <= reset_n && go && kind == 3'h1;
      byteDone <= reset_n && go && kind == 3'h2;
      busStart <= reset_n && go && kind == 3'h3;
      busStop <= reset_n && go && kind == 3'h4;
      spiIncompleteEvt <= reset_n && go && kind == 3'h5;
      rxAddr <= !reset_n ? 7'h2a : (go && kind == 3'h0) ? addrIn : rxAddr + 7'h35;
      rxReadReq <= !reset_n ? 1'b0 : (go && kind == 3'h0) ? bitIn : !rxReadReq;
      ackIn <= !reset_n ? 1'b0 : (go && kind == 3'h2) ? bitIn : !ackIn;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // The clock line has a pull-up, so it idles high and drops only for a commanded span.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         lowCnt <= 4'h0;
         sclIn <= 1'b1;
      end else begin
         lowCnt <= (go && kind == 3'h6) ? lowLen : (lowCnt != 4'h0) ? lowCnt - 4'h1 : 4'h0;
         sclIn <= !((go && kind == 3'h6) || lowCnt > 4'h1);
      end
   end
endmodule

// *** tb/smr_top_bench.sv ***
// Self-checking bench of the serial mode and status register block.
// Assumes smr_pkg, smr_top and smr_far_master are compiled first.
`timescale 1ns/1ps
`include "smr_cfg.svh"
module smr_top_bench;
   import smr_pkg::*;
   logic clk, reset_n, read, write, cfgOptionEn, subClkIn, periodMatch, go, bitIn, sawLow, v;
   logic [4:0] address;
   logic [31:0] writedata, readdata, rd;
   logic [3:0] byteenable, lowLen;
   logic [2:0] kind;
   logic [6:0] addrIn, rxAddr;
   logic [15:0] h;
   logic waitrequest, irq, sclIn, sclFiltered, rxAddrValid, rxReadReq, byteStart, byteDone;
   logic ackIn, busStart, busStop, spiIncompleteEvt, spiClkOut, spiClkOe, twoWireFuncEn;
   logic spiFuncEn, moduleClkEn, slaveTransmitSel, ackSendSel, addressWakeEn;
   smr_byte_t sa;
   int nErrors = 0;
   int checksDone = 0;
   int p;
   // Rows: mode [10:8], debounce [5:4], low length [3:1], low reaches output [0].
   localparam logic [76:0] GLITCH_TAB = {11'h603, 11'h612, 11'h615, 11'h626, 11'h636,
      11'h639, 11'h533};

   smr_top u_smr_top (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .irq(irq), .cfgOptionEn(cfgOptionEn), .subClkIn(subClkIn),
      .periodMatch(periodMatch), .sclIn(sclIn), .sclFiltered(sclFiltered),
      .rxAddrValid(rxAddrValid), .rxAddr(rxAddr), .rxReadReq(rxReadReq),
      .byteStart(byteStart), .byteDone(byteDone), .ackIn(ackIn), .busStart(busStart),
      .busStop(busStop), .spiIncompleteEvt(spiIncompleteEvt), .spiClkOut(spiClkOut),
      .spiClkOe(spiClkOe), .twoWireFuncEn(twoWireFuncEn), .spiFuncEn(spiFuncEn),
      .moduleClkEn(moduleClkEn), .slaveTransmitSel(slaveTransmitSel),
      .ackSendSel(ackSendSel), .addressWakeEn(addressWakeEn));

   smr_far_master u_smr_far_master (.clk(clk), .reset_n(reset_n), .go(go), .kind(kind),
      .addrIn(addrIn), .bitIn(bitIn), .lowLen(lowLen), .sclIn(sclIn),
      .rxAddrValid(rxAddrValid), .rxAddr(rxAddr), .rxReadReq(rxReadReq),
      .byteStart(byteStart), .byteDone(byteDone), .ackIn(ackIn), .busStart(busStart),
      .busStop(busStop), .spiIncompleteEvt(spiIncompleteEvt));

   ////////////////////////////////////////////////////////////////////////////////
   // Verdict and comparison helpers.
   task automatic complete_run();
      if (nErrors == 0 && checksDone > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         nErrors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Expected master clock period: four cycles, times four per code step.
   function automatic int expPeriod(input smr_mode_t m);
      return 4 << (2 * m);
   endfunction

   function automatic smr_byte_t modeWord(input smr_mode_t m, input smr_deb_t d, input logic en);
      return {m, 1'b0, d, en, 1'b0};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // One bus cycle, entered just after a rising edge; the request stands until waitrequest
   // is seen low or 20 clocks have passed, after which the cycle is counted as an error.
   task automatic busCycle(input logic wr, input logic [4:0] a, input smr_byte_t d,
         input logic [3:0] be);
      int n;
      n = 0;
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= {24'h0, d};
      byteenable <= be;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      rd = readdata;
      if (n >= 20) nErrors++;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [4:0] a, input smr_byte_t d);
      busCycle(1'b1, a, d, 4'hf);
   endtask

   task automatic rdchk(input logic [4:0] a, input smr_byte_t exp, input string what);
      busCycle(1'b0, a, 8'h00, 4'hf);
      check(what, rd, {24'h0, exp});
   endtask

   // Commands one far-side event and waits until its flag has landed.
   task automatic fire(input logic [2:0] k, input logic [6:0] a, input logic b,
         input logic [3:0] len);
      go <= 1'b1;
      kind <= k;
      addrIn <= a;
      bitIn <= b;
      lowLen <= len;
      @(posedge clk);
      go <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   // Rising edges between two rising edges of the master clock.
   task automatic period(output int q);
      int n;
      n = 0;
      q = 0;
      while (spiClkOut !== 1'b0 && n < 200) begin @(posedge clk); n++; end
      while (spiClkOut !== 1'b1 && n < 200) begin @(posedge clk); n++; end
      while (spiClkOut !== 1'b0 && n < 400) begin @(posedge clk); n++; q++; end
      while (spiClkOut !== 1'b1 && n < 400) begin @(posedge clk); n++; q++; end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, glitch watcher and watchdog; the run needs a few thousand cycles at most.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      if (sclFiltered === 1'b0) sawLow <= 1'b1;
   end

   initial begin
      repeat (20000) @(posedge clk);
      nErrors++;
      complete_run();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      void'($urandom(32'h905f));
      {reset_n, read, write, cfgOptionEn, subClkIn, periodMatch, go, bitIn, sawLow} = 9'h0;
      {address, writedata, byteenable, lowLen, kind, addrIn} = '0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rdchk(`SMR_OFF_MODE, `SMR_RST_MODE, "mode reset");
      rdchk(`SMR_OFF_STAT, `SMR_RST_STAT, "status reset");
      rdchk(`SMR_OFF_IRQ_STATUS, 8'h00, "irq status reset");
      rdchk(`SMR_OFF_IRQ_MASK, 8'h00, "irq mask reset");
      rdchk(`SMR_OFF_SLAVE_ADDR, `SMR_RST_SLAVE_ADDR, "slave address reset");
      wr(5'h14, 8'h5a);
      rdchk(5'h14, 8'h00, "unmapped read");
      wr(`SMR_OFF_MODE, 8'hff);
      rdchk(`SMR_OFF_MODE, 8'hef, "mode bit four");
      busCycle(1'b1, `SMR_OFF_MODE, 8'h00, 4'he);
      rdchk(`SMR_OFF_MODE, 8'hef, "lane off write");
      check("option off enable", moduleClkEn, 1'b0);
      cfgOptionEn <= 1'b1;
      for (int m = 0; m < 3; m++) begin
         wr(`SMR_OFF_MODE, modeWord(m[2:0], 2'h0, 1'b1));
         period(p);
         check("master period", p, expPeriod(m[2:0]));
         check("master clock drive", {spiClkOe, spiFuncEn}, 2'b11);
      end
      wr(`SMR_OFF_MODE, modeWord(3'h3, 2'h0, 1'b1));
      for (int i = 0; i < 16; i++) begin
         if (i >= 2) check("sub clock copy", spiClkOut, h[i-2]);
         h[i] = $urandom;
         subClkIn <= h[i];
         @(posedge clk);
      end
      wr(`SMR_OFF_MODE, modeWord(3'h4, 2'h0, 1'b1));
      for (int i = 0; i < 2; i++) begin
         v = spiClkOut;
         periodMatch <= 1'b1;
         @(posedge clk);
         periodMatch <= 1'b0;
         repeat (2) @(posedge clk);
         check("timer clock", spiClkOut, !v);
      end
      for (int m = 5; m < 8; m++) begin
         wr(`SMR_OFF_MODE, modeWord(m[2:0], 2'h0, 1'b1));
         repeat (8) @(posedge clk);
         check("no own clock", {spiClkOe, spiClkOut}, 2'b00);
      end
      // Glitch table: mode, debounce, low length, whether the low reaches the output.
      for (int t = 0; t < 7; t++) begin
         logic [10:0] row;
         row = GLITCH_TAB[t*11 +: 11];
         wr(`SMR_OFF_MODE, modeWord(row[10:8], row[5:4], 1'b1));
         sawLow <= 1'b0;
         fire(3'h6, 7'h00, 1'b0, row[3:0] >> 1);
         repeat (10) @(posedge clk);
         check("debounce pass", sawLow, row[0]);
      end
      wr(`SMR_OFF_MODE, modeWord(3'h6, 2'h0, 1'b0));
      check("disabled pins", {twoWireFuncEn, spiFuncEn, moduleClkEn}, 3'b000);
      wr(`SMR_OFF_MODE, modeWord(3'h6, 2'h0, 1'b1));
      check("two-wire pins", {twoWireFuncEn, spiFuncEn, moduleClkEn}, 3'b101);
      sa = $urandom;
      wr(`SMR_OFF_SLAVE_ADDR, sa);
      wr(`SMR_OFF_IRQ_MASK, 8'h07);
      fire(3'h0, sa[7:1] ^ (7'h01 << ($urandom % 7)), 1'b1, 4'h0);
      rdchk(`SMR_OFF_STAT, 8'h81, "address miss");
      fire(3'h0, sa[7:1], 1'b1, 4'h0);
      rdchk(`SMR_OFF_STAT, 8'hc5, "address hit");
      rdchk(`SMR_OFF_IRQ_STATUS, 8'h01, "match event");
      check("match irq", irq, 1'b1);
      wr(`SMR_OFF_IRQ_STATUS, 8'h01);
      check("irq cleared", irq, 1'b0);
      fire(3'h1, 7'h00, 1'b0, 4'h0);
      rdchk(`SMR_OFF_STAT, 8'h45, "byte in flight");
      fire(3'h2, 7'h00, 1'b1, 4'h0);
      rdchk(`SMR_OFF_STAT, 8'hc5, "byte done");
      check("done irq", irq, 1'b1);
      wr(`SMR_OFF_IRQ_MASK, 8'h00);
      check("masked irq", irq, 1'b0);
      fire(3'h3, 7'h00, 1'b0, 4'h0);
      wr(`SMR_OFF_STAT, 8'h5a);
      rdchk(`SMR_OFF_STAT, 8'hbb, "read-only flags");
      check("select outputs", {slaveTransmitSel, ackSendSel, addressWakeEn}, 3'b111);
      wr(`SMR_OFF_MODE, modeWord(3'h6, 2'h0, 1'b0));
      wr(`SMR_OFF_MODE, modeWord(3'h6, 2'h0, 1'b1));
      rdchk(`SMR_OFF_STAT, 8'h9b, "enable rise flags");
      wr(`SMR_OFF_IRQ_STATUS, 8'h07);
      fire(3'h5, 7'h00, 1'b0, 4'h0);
      rdchk(`SMR_OFF_MODE, 8'hc2, "incomplete in two-wire");
      wr(`SMR_OFF_MODE, modeWord(3'h5, 2'h0, 1'b0));
      sa = $urandom;
      wr(`SMR_OFF_SLAVE_ADDR, sa);
      wr(`SMR_OFF_MODE, modeWord(3'h5, 2'h0, 1'b1));
      rdchk(`SMR_OFF_SLAVE_ADDR, sa, "setting kept");
      fire(3'h5, 7'h00, 1'b0, 4'h0);
      rdchk(`SMR_OFF_MODE, 8'ha3, "incomplete in slave");
      rdchk(`SMR_OFF_IRQ_STATUS, 8'h04, "incomplete event");
      complete_run();
   end
endmodule
